// *** core/adc_general_config_regs.sv ***
`timescale 1ns/100ps
`include "adc_gen_cfg_params.svh"
module adc_general_config_regs
    import adc_gen_cfg_pkg::*;
#(
    parameter int SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic serialClk,
    input wire logic chipSelect_n,
    input wire logic hostSerialDataLineIn,
    output logic hostSerialDataLineOut,
    output logic hostSerialDataLineOe,
    output logic serialDataOut,
    output logic serialDataOutOe,
    output logic softResetOut,
    output logic [23:0] bankWindowPtr,
    output page_t bankPage,
    output logic converterPageSel,
    output logic topPageSel,
    output logic threeWireMode
);
    initial begin
        if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255)
            $error("SOFT_RESET_CYCLES must be 1 to 255");
    end

    localparam logic [7:0] RST_LEN = 8'(SOFT_RESET_CYCLES);

    logic sclkF, csnF, sdinF;
    logic sclkPrev;
    phase_t phase, next_phase;
    logic [4:0] bitCnt, next_bitCnt;
    logic [23:0] rxShift, next_rxShift;
    logic [7:0] txShift, next_txShift;
    logic isRead, next_isRead;
    logic [11:0] addr, next_addr;
    logic [1:0] resetBits, next_resetBits;
    logic [7:0] rstCnt, next_rstCnt;
    logic [7:0] ptrLow, next_ptrLow, ptrMid, next_ptrMid, ptrHigh, next_ptrHigh;
    logic wireMode, next_wireMode;
    logic [7:0] convPage, next_convPage;
    logic topPage, next_topPage;
    logic next_sdinOut, next_sdinOe, next_sdout, next_sdoutOe, next_softReset;
    page_t next_bankPage;
    logic rise, fall;
    logic [23:0] shifted;

    // pins from the host pass the three-stage synchroniser
    pin_sync #(
        .WIDTH(3),
        .RESET_VAL(3'b010)
    ) u_pin_sync (
        .core_clk(core_clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn({serialClk, chipSelect_n, hostSerialDataLineIn}),
        .pinSync({sclkF, csnF, sdinF})
    );

    // pointer decode to a page code
    function automatic page_t pageDecode(input logic [23:0] ptr);
        case (ptr)
            `PTR_MAIN_ONE: pageDecode = PAGE_MAIN_CONVERTER_ONE;
            `PTR_MAIN_TWO: pageDecode = PAGE_MAIN_CONVERTER_TWO;
            `PTR_FUNC_ONE: pageDecode = PAGE_FUNC_CONVERTER_ONE;
            `PTR_FUNC_TWO: pageDecode = PAGE_FUNC_CONVERTER_TWO;
            `PTR_LINK_DIGITAL: pageDecode = PAGE_LINK_DIGITAL;
            default: pageDecode = PAGE_NONE;
        endcase
    endfunction

    // read mux; reserved bits and unmapped addresses read zero
    function automatic logic [7:0] regRead(input logic [11:0] a);
        regRead = 8'h00;
        case (a)
            `OFS_SOFT_RESET_CTRL: begin
                regRead[`POS_RESET_HI] = resetBits[1];
                regRead[`POS_RESET_LO] = resetBits[0];
            end
            `OFS_BANK_PTR_LOW: regRead = ptrLow;
            `OFS_BANK_PTR_MID: regRead = ptrMid;
            `OFS_BANK_PTR_HIGH: regRead = ptrHigh;
            `OFS_SERIAL_WIRE_MODE: regRead[`POS_WIRE_MODE] = wireMode;
            `OFS_CONVERTER_PAGE_EN: regRead = convPage;
            `OFS_TOP_PAGE_EN: regRead[`POS_TOP_PAGE] = topPage;
            default: regRead = 8'h00;
        endcase
    endfunction

    assign rise = sclkF & ~sclkPrev;
    assign fall = ~sclkF & sclkPrev;
    assign shifted = {rxShift[22:0], sdinF};

    // serial frame, register writes and soft reset sequencing
    always_comb begin
        next_phase = phase;
        next_bitCnt = bitCnt;
        next_rxShift = rxShift;
        next_txShift = txShift;
        next_isRead = isRead;
        next_addr = addr;
        next_resetBits = resetBits;
        next_rstCnt = rstCnt;
        next_ptrLow = ptrLow;
        next_ptrMid = ptrMid;
        next_ptrHigh = ptrHigh;
        next_wireMode = wireMode;
        next_convPage = convPage;
        next_topPage = topPage;
        next_sdinOut = hostSerialDataLineOut;
        next_sdinOe = hostSerialDataLineOe;
        next_sdout = serialDataOut;
        next_sdoutOe = serialDataOutOe;
        next_softReset = softResetOut;
        if (csnF) begin
            next_phase = PH_IDLE;
            next_bitCnt = 5'd0;
            next_sdinOe = 1'b0;
            next_sdoutOe = 1'b0;
        end else if (rise && phase != PH_DONE) begin
            next_rxShift = shifted;
            next_bitCnt = bitCnt + 5'd1;
            next_phase = (phase == PH_IDLE) ? PH_HEAD : phase;
            if (bitCnt == 5'(`FRAME_HEAD_BITS - 1)) begin
                next_phase = PH_DATA;
                next_isRead = shifted[`POS_READ_FLAG];
                next_addr = shifted[11:0];
                next_txShift = regRead(shifted[11:0]);
            end else if (bitCnt == 5'(`FRAME_BITS - 1)) begin
                next_phase = PH_DONE;
                if (!isRead) begin
                    case (addr)
                        `OFS_SOFT_RESET_CTRL: begin
                            next_resetBits = {shifted[`POS_RESET_HI], shifted[`POS_RESET_LO]};
                            if (shifted[`POS_RESET_HI] && shifted[`POS_RESET_LO]) begin
                                next_rstCnt = RST_LEN;
                                next_softReset = 1'b1;
                            end
                        end
                        `OFS_BANK_PTR_LOW: next_ptrLow = shifted[7:0];
                        `OFS_BANK_PTR_MID: next_ptrMid = shifted[7:0];
                        `OFS_BANK_PTR_HIGH: next_ptrHigh = shifted[7:0];
                        `OFS_SERIAL_WIRE_MODE: next_wireMode = shifted[`POS_WIRE_MODE];
                        `OFS_CONVERTER_PAGE_EN: next_convPage = shifted[7:0];
                        `OFS_TOP_PAGE_EN: next_topPage = shifted[`POS_TOP_PAGE];
                        default: next_topPage = topPage;
                    endcase
                end
            end
        end else if (fall && phase == PH_DATA && isRead) begin
            // read data leaves msb first on the falling edge
            next_txShift = {txShift[6:0], 1'b0};
            if (wireMode) begin
                next_sdinOut = txShift[7];
                next_sdinOe = 1'b1;
            end else begin
                next_sdout = txShift[7];
                next_sdoutOe = 1'b1;
            end
        end
        // internal reset: hold, then restore defaults and clear both bits
        if (rstCnt != 8'd0) begin
            next_rstCnt = rstCnt - 8'd1;
            if (rstCnt == 8'd1) begin
                next_softReset = 1'b0;
                next_resetBits = 2'b00;
                next_ptrLow = `RST_BYTE;
                next_ptrMid = `RST_BYTE;
                next_ptrHigh = `RST_BYTE;
                next_wireMode = 1'b0;
                next_convPage = `RST_BYTE;
                next_topPage = 1'b0;
            end
        end
        next_bankPage = pageDecode({next_ptrHigh, next_ptrMid, next_ptrLow});
    end

    // state registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclkPrev <= 1'b0;
            phase <= PH_IDLE;
            bitCnt <= 5'd0;
            rxShift <= 24'h000000;
            txShift <= 8'h00;
            isRead <= 1'b0;
            addr <= 12'h000;
            resetBits <= 2'b00;
            rstCnt <= 8'h00;
            ptrLow <= `RST_BYTE;
            ptrMid <= `RST_BYTE;
            ptrHigh <= `RST_BYTE;
            wireMode <= 1'b0;
            convPage <= `RST_BYTE;
            topPage <= 1'b0;
            hostSerialDataLineOut <= 1'b0;
            hostSerialDataLineOe <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOutOe <= 1'b0;
            softResetOut <= 1'b0;
            bankWindowPtr <= 24'h000000;
            bankPage <= PAGE_NONE;
            converterPageSel <= 1'b0;
            topPageSel <= 1'b0;
            threeWireMode <= 1'b0;
        end else if (clkEn) begin
            sclkPrev <= sclkF;
            phase <= next_phase;
            bitCnt <= next_bitCnt;
            rxShift <= next_rxShift;
            txShift <= next_txShift;
            isRead <= next_isRead;
            addr <= next_addr;
            resetBits <= next_resetBits;
            rstCnt <= next_rstCnt;
            ptrLow <= next_ptrLow;
            ptrMid <= next_ptrMid;
            ptrHigh <= next_ptrHigh;
            wireMode <= next_wireMode;
            convPage <= next_convPage;
            topPage <= next_topPage;
            hostSerialDataLineOut <= next_sdinOut;
            hostSerialDataLineOe <= next_sdinOe;
            serialDataOut <= next_sdout;
            serialDataOutOe <= next_sdoutOe;
            softResetOut <= next_softReset;
            bankWindowPtr <= {next_ptrHigh, next_ptrMid, next_ptrLow};
            bankPage <= next_bankPage;
            // host keeps the two page selects exclusive
            converterPageSel <= (next_convPage == `CONVERTER_PAGE_ON);
            topPageSel <= next_topPage;
            threeWireMode <= next_wireMode;
        end
    end
endmodule // adc_general_config_regs

// *** core/adc_gen_cfg_params.svh ***
`ifndef ADC_GEN_CFG_PARAMS_SVH
`define ADC_GEN_CFG_PARAMS_SVH

// register offsets on the 12-bit serial address
`define OFS_SOFT_RESET_CTRL 12'h000
`define OFS_BANK_PTR_LOW 12'h002
`define OFS_BANK_PTR_MID 12'h003
`define OFS_BANK_PTR_HIGH 12'h004
`define OFS_SERIAL_WIRE_MODE 12'h010
`define OFS_CONVERTER_PAGE_EN 12'h011
`define OFS_TOP_PAGE_EN 12'h012

// field positions
`define POS_RESET_HI 7
`define POS_RESET_LO 0
`define POS_WIRE_MODE 0
`define POS_TOP_PAGE 2

// reset value and converter page enable code
`define RST_BYTE 8'h00
`define CONVERTER_PAGE_ON 8'hff

// window pointer codes
`define PTR_MAIN_ONE 24'h680000
`define PTR_MAIN_TWO 24'h680100
`define PTR_FUNC_ONE 24'h610000
`define PTR_FUNC_TWO 24'h610100
`define PTR_LINK_DIGITAL 24'h690000

// serial frame: read flag, 3 spare bits, 12 address bits, 8 data bits
`define FRAME_HEAD_BITS 16
`define FRAME_BITS 24
`define POS_READ_FLAG 15

// internal reset pulse length in core clocks
`define SOFT_RESET_CYCLES 16

`endif

// *** core/adc_gen_cfg_pkg.sv ***
package adc_gen_cfg_pkg;

    // serial frame progress
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_HEAD = 2'b01,
        PH_DATA = 2'b10,
        PH_DONE = 2'b11
    } phase_t;

    // page chosen by the bank window pointer
    typedef enum logic [2:0] {
        PAGE_NONE = 3'b000,
        PAGE_MAIN_CONVERTER_ONE = 3'b001,
        PAGE_MAIN_CONVERTER_TWO = 3'b010,
        PAGE_FUNC_CONVERTER_ONE = 3'b011,
        PAGE_FUNC_CONVERTER_TWO = 3'b100,
        PAGE_LINK_DIGITAL = 3'b101
    } page_t;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/100ps
// three-stage pin synchroniser; the output follows once stages two and three agree
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    initial begin
        if (WIDTH < 1) $error("pin_sync needs at least one bit");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1, s2, s3, filt;
            logic next_filt;
            // accept a change only when the two settled stages agree
            always_comb begin
                next_filt = (s2 == s3) ? s3 : filt;
            end
            // register the stages and the filtered level
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    s1 <= RESET_VAL[i];
                    s2 <= RESET_VAL[i];
                    s3 <= RESET_VAL[i];
                    filt <= RESET_VAL[i];
                end else if (clkEn) begin
                    s1 <= pinIn[i];
                    s2 <= s1;
                    s3 <= s2;
                    filt <= next_filt;
                end
            end
            assign pinSync[i] = filt;
        end
    endgenerate
endmodule // pin_sync

// *** dv/adc_general_config_regs_props.sv ***
`timescale 1ns/100ps
module adc_general_config_regs_props
    import adc_gen_cfg_pkg::*;
#(
    parameter int SOFT_RESET_CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chipSelect_n,
    input wire logic hostSerialDataLineOe,
    input wire logic serialDataOutOe,
    input wire logic softResetOut,
    input wire logic [23:0] bankWindowPtr,
    input wire page_t bankPage,
    input wire logic converterPageSel,
    input wire logic topPageSel,
    input wire logic threeWireMode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [8:0] pulseLen;
    logic [8:0] next_pulseLen;
    // counts how long the soft reset pulse has stood
    always_comb next_pulseLen = softResetOut ? pulseLen + 9'h001 : 9'h000;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) pulseLen <= 9'h000;
        else pulseLen <= next_pulseLen;
    end
    // page expected for a pointer value
    function automatic page_t pageOf(input logic [23:0] p);
        case (p)
            24'h680000: return PAGE_MAIN_CONVERTER_ONE;
            24'h680100: return PAGE_MAIN_CONVERTER_TWO;
            24'h610000: return PAGE_FUNC_CONVERTER_ONE;
            24'h610100: return PAGE_FUNC_CONVERTER_TWO;
            24'h690000: return PAGE_LINK_DIGITAL;
            default: return PAGE_NONE;
        endcase
    endfunction
    a_pulse_not_long: assert property (softResetOut |-> pulseLen < SOFT_RESET_CYCLES)
        else $error("soft reset pulse too long");
    a_pulse_full_len: assert property ($fell(softResetOut) |-> pulseLen == SOFT_RESET_CYCLES)
        else $error("soft reset pulse too short");
    a_reset_clears_regs: assert property ($fell(softResetOut) |-> ##[0:2]
        (bankWindowPtr == 24'h000000 && !converterPageSel && !topPageSel && !threeWireMode))
        else $error("registers not cleared by soft reset");
    a_page_decode: assert property (bankPage == pageOf(bankWindowPtr))
        else $error("page decode wrong");
    a_four_wire_quiet: assert property (!threeWireMode |-> !hostSerialDataLineOe)
        else $error("shared line driven in four wire mode");
    a_three_wire_quiet: assert property (threeWireMode |-> !serialDataOutOe)
        else $error("data out driven in three wire mode");
    a_conv_sel_frame: assert property ($rose(converterPageSel) |-> !chipSelect_n)
        else $error("converter page set outside a frame");
    a_top_sel_frame: assert property ($rose(topPageSel) |-> !chipSelect_n)
        else $error("top page set outside a frame");
    c_soft_reset: cover property ($rose(softResetOut));
    c_three_wire_read: cover property (threeWireMode && hostSerialDataLineOe);
    c_link_page: cover property (bankPage == PAGE_LINK_DIGITAL);
endmodule // adc_general_config_regs_props

bind adc_general_config_regs adc_general_config_regs_props #(
    .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)
) chk (.core_clk, .reset, .chipSelect_n, .hostSerialDataLineOe, .serialDataOutOe,
    .softResetOut, .bankWindowPtr, .bankPage, .converterPageSel, .topPageSel, .threeWireMode);

// *** dv/spi_host_model.sv ***
`timescale 1ns/100ps
module spi_host_model (
    input wire logic core_clk,
    input wire logic threeWire,
    input wire logic sdoPin,
    input wire logic sdWire,
    output logic sclk,
    output logic csN,
    output logic hostData
);
    // idle: clock still, not selected
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        hostData = 1'b0;
    end
    // one serial clock level, longer than the five clocks needed
    task automatic half;
        repeat (8) @(negedge core_clk);
    endtask
    // one 24-bit frame, msb first; released line shows a changing pattern
    task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 3'h0, a, d};
        q = 8'h00;
        @(negedge core_clk);
        csN = 1'b0;
        half();
        for (int i = 23; i >= 0; i--) begin
            hostData = (rd && i < 8) ? ~hostData : f[i];
            half();
            sclk = 1'b1;
            if (i < 8) q[i] = threeWire ? sdWire : sdoPin;
            half();
            sclk = 1'b0;
        end
        half();
        csN = 1'b1;
        hostData = ~hostData;
        half();
    endtask
endmodule // spi_host_model

// *** dv/adc_general_config_regs_tb.sv ***
`timescale 1ns/100ps
module adc_general_config_regs_tb
    import adc_gen_cfg_pkg::*;
;
    localparam int SRC = 4;
    localparam logic [23:0] PTRS [6] = '{24'h680000, 24'h680100, 24'h610000,
        24'h610100, 24'h690000, 24'h123456};
    localparam page_t PAGES [6] = '{PAGE_MAIN_CONVERTER_ONE, PAGE_MAIN_CONVERTER_TWO,
        PAGE_FUNC_CONVERTER_ONE, PAGE_FUNC_CONVERTER_TWO, PAGE_LINK_DIGITAL, PAGE_NONE};
    localparam logic [11:0] ADRS [8] = '{12'h000, 12'h002, 12'h003, 12'h004, 12'h010,
        12'h011, 12'h012, 12'h005};
    logic core_clk, reset, clkEn, serialClk, chipSelect_n, hostData, wire3;
    logic hostSerialDataLineOut, hostSerialDataLineOe, serialDataOut, serialDataOutOe;
    logic softResetOut, converterPageSel, topPageSel, threeWireMode;
    logic [23:0] bankWindowPtr;
    page_t bankPage;
    wire hostSerialDataLineIn = hostSerialDataLineOe ? hostSerialDataLineOut : hostData;
    int errTotal = 0;
    int testsRun = 0;
    int cyc = 0;
    int pulses = 0;
    adc_general_config_regs #(.SOFT_RESET_CYCLES(SRC)) DUT (.core_clk, .reset, .clkEn,
        .serialClk, .chipSelect_n, .hostSerialDataLineIn, .hostSerialDataLineOut,
        .hostSerialDataLineOe, .serialDataOut, .serialDataOutOe, .softResetOut,
        .bankWindowPtr, .bankPage, .converterPageSel, .topPageSel, .threeWireMode);
    // a released data out pin shows the inverse of its held level
    spi_host_model host (.core_clk(core_clk), .threeWire(wire3),
        .sdoPin(serialDataOutOe ? serialDataOut : ~serialDataOut),
        .sdWire(hostSerialDataLineIn), .sclk(serialClk), .csN(chipSelect_n),
        .hostData(hostData));
    // clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog and soft reset pulse length
    always @(posedge core_clk) begin
        cyc++;
        if (softResetOut === 1'b1) pulses++;
        if (cyc == 80000) begin
            errTotal++;
            testDone();
        end
    end
    task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a, d, q);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.xfer(1'b1, a, 8'h00, q);
        check($sformatf("reg %h", a), {16'h0, e}, {16'h0, q});
    endtask
    // reset values, unmapped place ignored
    task automatic t_reset_vals;
        foreach (ADRS[i]) rdc(ADRS[i], 8'h00);
        wr(12'h005, 8'hff);
        rdc(12'h005, 8'h00);
        check("page", {21'h0, PAGE_NONE}, {21'h0, bankPage});
    endtask
    // pointer bytes and page decode
    task automatic t_pointer;
        for (int i = 0; i < 6; i++) begin
            wr(12'h004, PTRS[i][23:16]);
            wr(12'h003, PTRS[i][15:8]);
            wr(12'h002, PTRS[i][7:0]);
            check("ptr", PTRS[i], bankWindowPtr);
            check("page", {21'h0, PAGES[i]}, {21'h0, bankPage});
            for (int j = 0; j < 3; j++) rdc(12'(2 + j), PTRS[i][8*j+:8]);
        end
    endtask
    // top page and converter page selects
    task automatic t_pages;
        wr(12'h012, 8'h04);
        check("top", 24'h1, {23'h0, topPageSel});
        rdc(12'h012, 8'h04);
        wr(12'h012, 8'h00);
        check("top", 24'h0, {23'h0, topPageSel});
        wr(12'h011, 8'hfe);
        check("conv", 24'h0, {23'h0, converterPageSel});
        wr(12'h011, 8'hff);
        check("conv", 24'h1, {23'h0, converterPageSel});
        rdc(12'h011, 8'hff);
        wr(12'h011, 8'h00);
        check("conv", 24'h0, {23'h0, converterPageSel});
    endtask
    // three-wire reads over the shared line, then back to four wires
    task automatic t_three_wire;
        wr(12'h010, 8'h01);
        check("mode", 24'h1, {23'h0, threeWireMode});
        wire3 = 1'b1;
        rdc(12'h010, 8'h01);
        rdc(12'h003, 8'h34);
        wr(12'h010, 8'h00);
        wire3 = 1'b0;
        check("mode", 24'h0, {23'h0, threeWireMode});
        rdc(12'h010, 8'h00);
    endtask
    // one reset bit alone stores only; both together reset and clear
    task automatic t_soft_reset;
        wr(12'h000, 8'h80);
        rdc(12'h000, 8'h80);
        wr(12'h000, 8'h01);
        rdc(12'h000, 8'h01);
        check("pulses", 24'h0, 24'(pulses));
        wr(12'h000, 8'h81);
        repeat (SRC + 8) @(negedge core_clk);
        check("pulses", 24'(SRC), 24'(pulses));
        check("ptr", 24'h0, bankWindowPtr);
        rdc(12'h000, 8'h00);
        rdc(12'h002, 8'h00);
    endtask
    // main sequence
    initial begin
        clkEn = 1'b1;
        reset = 1'b1;
        wire3 = 1'b0;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        repeat (6) @(negedge core_clk);
        t_reset_vals();
        t_pointer();
        t_pages();
        t_three_wire();
        t_soft_reset();
        testDone();
    end
endmodule // adc_general_config_regs_tb
